// ---- common/ppc_pkg.sv ----
package ppc_pkg;

  // register indices; the bus byte address is four times the index
  localparam logic [31:0] PPC_IDX_P5_PULL  = 32'h0ffffc4a;
  localparam logic [31:0] PPC_IDX_P9_LAT   = 32'hfffff412;
  localparam logic [31:0] PPC_IDX_P9_LAT_H = 32'hfffff413;
  localparam logic [31:0] PPC_IDX_P9_DIR   = 32'hfffff432;
  localparam logic [31:0] PPC_IDX_P9_DIR_H = 32'hfffff433;
  localparam logic [31:0] PPC_IDX_P5_MODE  = 32'hfffff44a;
  localparam logic [31:0] PPC_IDX_P5_FUNC  = 32'hfffff46a;

  // only this many index bits are decoded (paddr[13:2])
  localparam int          PPC_DEC_W = 12;

  // reset values
  localparam logic [7:0]  PPC_RST_P5_PULL = 8'h00;
  localparam logic [7:0]  PPC_RST_P5_MODE = 8'h00;
  localparam logic [7:0]  PPC_RST_P5_FUNC = 8'h00;
  localparam logic [15:0] PPC_RST_P9_LAT  = 16'h0000;
  localparam logic [15:0] PPC_RST_P9_DIR  = 16'hffff;

  // implemented bit masks
  localparam logic [7:0]  PPC_P5_MASK = 8'h3f;
  localparam logic [15:0] PPC_P9_MASK = 16'he3c3;

  // pin positions on port 5
  localparam int PPC_P5_TMR16 = 0;
  localparam int PPC_P5_TI8   = 1;
  localparam int PPC_P5_TO8   = 2;
  localparam int PPC_P5_SDI   = 3;
  localparam int PPC_P5_SDO   = 4;
  localparam int PPC_P5_SCK   = 5;

  // signals from on-chip peripherals toward port 5
  typedef struct packed {
    logic [5:0] rtp;          // realtime_output_bit0..5
    logic       csi_clk_out;  // serial clock when master
    logic       csi_clk_oe;   // serial clock drive enable
    logic       csi_data_out; // serial data out
    logic       tmr8_out;     // timer8_0_output
  } ppc_periph_t;

  // signals from port 5 pins toward peripherals
  typedef struct packed {
    logic [5:0] key_return;   // key_return_input_0..5
    logic       csi_clk_in;
    logic       csi_data_in;
    logic       tmr8_cnt_in;  // timer8_0_count_input
    logic       tmr16_cap_in; // timer16_1_capture_input
  } ppc_pin_in_t;

  // whole register state of the block
  typedef struct packed {
    logic [7:0]  p5_mode;
    logic [7:0]  p5_func;
    logic [7:0]  p5_pull;
    logic [15:0] p9_lat;
    logic [15:0] p9_dir;
    logic [31:0] prdata;
    logic        pslverr;
  } ppc_state_t;

endpackage : ppc_pkg

// ---- src/ppc_port_ctrl.sv ----
// Added by the designer: the APB register port.
`timescale 1ns/1ps

// Overview of operation
// R1 - mode bit picks port or alternate use
// R2 - pin 3 feeds key return or serial
// R3 - pin 5 function: serial clock or rtp5
// R4 - pin 4 function: serial data or rtp4
// R5 - pin 3 function: serial input or rtp3
// R6 - pin 2 function: timer output or rtp2
// R7 - pin 1 function: timer count or rtp1
// R8 - pin 0 function: capture input or rtp0
// R9 - pull-up bit connects pin pull-up
// R10 - port 7 input only, feeds analog
// R11 - port 9 nine pins, rest read zero
// R12 - port 9 latch drives pin, resets zero
// R13 - port 9 direction, zero means output
// R14 - port 9 latch word and high alias
// R15 - port 9 direction word and high alias
// R16 - alternate function owns pin drive
// R17 - read gives pin in input mode
// R18 - latch writes land in input mode
module ppc_port_ctrl
  import ppc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  input  wire logic [5:0]  p5_pin_in,
  output      logic [5:0]  p5_pin_out,
  output      logic [5:0]  p5_pin_oe,
  output      logic [5:0]  p5_pullup_en,
  input  wire logic [5:0]  p5_port_out,
  input  wire logic [5:0]  p5_port_oe,
  input  wire ppc_periph_t periph,
  output      ppc_pin_in_t pin_to_periph,
  input  wire logic [7:0]  p7_pin_in,
  output      logic [7:0]  analog_channel_input,
  output      logic [7:0]  p7_level,
  input  wire logic [15:0] p9_pin_in,
  output      logic [15:0] p9_pin_out,
  output      logic [15:0] p9_pin_oe
);

  ppc_state_t st_r;    // registered state
  ppc_state_t st_nxt;  // next state

  logic [PPC_DEC_W-1:0] idx;     // decoded register index
  logic                 setup;   // first cycle of a transfer
  logic                 wr_take; // write completes this edge
  logic [15:0]          p9_read; // port 9 read view
  logic [5:0]           alt;     // pins in alternate use
  logic [5:0]           fsel;    // function select per pin

  assign idx     = paddr[PPC_DEC_W+1:2];
  assign setup   = psel & ~penable;
  assign wr_take = psel & penable & pwrite;
  assign alt     = st_r.p5_mode[5:0];
  assign fsel    = st_r.p5_func[5:0];

  // input-mode pins show the pin, output-mode pins the latch
  assign p9_read = ((st_r.p9_dir & p9_pin_in) |
                    (~st_r.p9_dir & st_r.p9_lat)) & PPC_P9_MASK; // R17 R11

  // register next state, read capture in setup, writes in access
  always_comb begin
    st_nxt = st_r;
    if (setup) begin
      st_nxt.prdata  = 32'h00000000;
      st_nxt.pslverr = 1'b0;
      // reads are captured one cycle ahead so prdata is a flop
      if (idx == PPC_IDX_P5_PULL[PPC_DEC_W-1:0]) begin
        st_nxt.prdata[7:0] = st_r.p5_pull;
      end else if (idx == PPC_IDX_P5_MODE[PPC_DEC_W-1:0]) begin
        st_nxt.prdata[7:0] = st_r.p5_mode;
      end else if (idx == PPC_IDX_P5_FUNC[PPC_DEC_W-1:0]) begin
        st_nxt.prdata[7:0] = st_r.p5_func;
      end else if (idx == PPC_IDX_P9_LAT[PPC_DEC_W-1:0]) begin
        st_nxt.prdata[15:0] = p9_read; // R17
      end else if (idx == PPC_IDX_P9_LAT_H[PPC_DEC_W-1:0]) begin
        st_nxt.prdata[7:0] = p9_read[15:8]; // R14
      end else if (idx == PPC_IDX_P9_DIR[PPC_DEC_W-1:0]) begin
        st_nxt.prdata[15:0] = st_r.p9_dir & PPC_P9_MASK; // R11
      end else if (idx == PPC_IDX_P9_DIR_H[PPC_DEC_W-1:0]) begin
        st_nxt.prdata[7:0] = st_r.p9_dir[15:8] & PPC_P9_MASK[15:8]; // R15
      end else begin
        // unmapped: zero data and an error answer
        st_nxt.pslverr = 1'b1;
      end
    end
    if (wr_take) begin
      if (idx == PPC_IDX_P5_PULL[PPC_DEC_W-1:0]) begin
        if (pstrb[0]) begin
          st_nxt.p5_pull = pwdata[7:0] & PPC_P5_MASK; // R9
        end
      end else if (idx == PPC_IDX_P5_MODE[PPC_DEC_W-1:0]) begin
        if (pstrb[0]) begin
          st_nxt.p5_mode = pwdata[7:0] & PPC_P5_MASK; // R1
        end
      end else if (idx == PPC_IDX_P5_FUNC[PPC_DEC_W-1:0]) begin
        if (pstrb[0]) begin
          st_nxt.p5_func = pwdata[7:0] & PPC_P5_MASK;
        end
      end else if (idx == PPC_IDX_P9_LAT[PPC_DEC_W-1:0]) begin
        // latch takes the write whatever the direction
        if (pstrb[0]) begin
          st_nxt.p9_lat[7:0] = pwdata[7:0] & PPC_P9_MASK[7:0]; // R18
        end
        if (pstrb[1]) begin
          st_nxt.p9_lat[15:8] = pwdata[15:8] & PPC_P9_MASK[15:8]; // R14
        end
      end else if (idx == PPC_IDX_P9_LAT_H[PPC_DEC_W-1:0]) begin
        if (pstrb[0]) begin
          st_nxt.p9_lat[15:8] = pwdata[7:0] & PPC_P9_MASK[15:8]; // R14
        end
      end else if (idx == PPC_IDX_P9_DIR[PPC_DEC_W-1:0]) begin
        // unimplemented direction bits stay one, harmless and hidden
        if (pstrb[0]) begin
          st_nxt.p9_dir[7:0] = pwdata[7:0] | ~PPC_P9_MASK[7:0]; // R15
        end
        if (pstrb[1]) begin
          st_nxt.p9_dir[15:8] = pwdata[15:8] | ~PPC_P9_MASK[15:8];
        end
      end else if (idx == PPC_IDX_P9_DIR_H[PPC_DEC_W-1:0]) begin
        if (pstrb[0]) begin
          st_nxt.p9_dir[15:8] = pwdata[7:0] | ~PPC_P9_MASK[15:8]; // R15
        end
      end
    end
  end

  // one register for the whole state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.p5_mode <= PPC_RST_P5_MODE;
      st_r.p5_func <= PPC_RST_P5_FUNC;
      st_r.p5_pull <= PPC_RST_P5_PULL;
      st_r.p9_lat  <= PPC_RST_P9_LAT; // R12
      st_r.p9_dir  <= PPC_RST_P9_DIR; // R13
      st_r.prdata  <= 32'h00000000;
      st_r.pslverr <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // bus answer: every access phase completes at once
  assign pready  = psel & penable;
  assign prdata  = st_r.prdata;
  assign pslverr = st_r.pslverr & psel & penable;

  // port 5 pin drive: alternate use hands the pin to a peripheral
  always_comb begin
    p5_pin_out = p5_port_out;
    p5_pin_oe  = p5_port_oe;
    // pin 0: capture input or rtp0
    if (alt[PPC_P5_TMR16]) begin
      p5_pin_oe[PPC_P5_TMR16]  = fsel[PPC_P5_TMR16]; // R8 R16
      p5_pin_out[PPC_P5_TMR16] = fsel[PPC_P5_TMR16] & periph.rtp[0];
    end
    // pin 1: timer count input or rtp1
    if (alt[PPC_P5_TI8]) begin
      p5_pin_oe[PPC_P5_TI8]  = fsel[PPC_P5_TI8]; // R7 R16
      p5_pin_out[PPC_P5_TI8] = fsel[PPC_P5_TI8] & periph.rtp[1];
    end
    // pin 2: timer output or rtp2, always driven
    if (alt[PPC_P5_TO8]) begin
      p5_pin_oe[PPC_P5_TO8]  = 1'b1; // R16
      p5_pin_out[PPC_P5_TO8] = fsel[PPC_P5_TO8] ? periph.rtp[2]
                                                : periph.tmr8_out; // R6
    end
    // pin 3: serial data input or rtp3
    if (alt[PPC_P5_SDI]) begin
      p5_pin_oe[PPC_P5_SDI]  = fsel[PPC_P5_SDI]; // R5 R16
      p5_pin_out[PPC_P5_SDI] = fsel[PPC_P5_SDI] & periph.rtp[3];
    end
    // pin 4: serial data output or rtp4
    if (alt[PPC_P5_SDO]) begin
      p5_pin_oe[PPC_P5_SDO]  = 1'b1; // R16
      p5_pin_out[PPC_P5_SDO] = fsel[PPC_P5_SDO] ? periph.rtp[4]
                                                : periph.csi_data_out; // R4
    end
    // pin 5: serial clock is two-way, follows the serial unit
    if (alt[PPC_P5_SCK]) begin
      if (fsel[PPC_P5_SCK]) begin
        p5_pin_oe[PPC_P5_SCK]  = 1'b1; // R3
        p5_pin_out[PPC_P5_SCK] = periph.rtp[5];
      end else begin
        p5_pin_oe[PPC_P5_SCK]  = periph.csi_clk_oe; // R3 R16
        p5_pin_out[PPC_P5_SCK] = periph.csi_clk_out;
      end
    end
  end

  // pin levels toward peripherals; unselected inputs read zero
  always_comb begin
    pin_to_periph.key_return  = p5_pin_in & ~alt; // R1 R2
    pin_to_periph.csi_clk_in  = alt[PPC_P5_SCK] & ~fsel[PPC_P5_SCK] &
                                p5_pin_in[PPC_P5_SCK]; // R3
    pin_to_periph.csi_data_in = alt[PPC_P5_SDI] & ~fsel[PPC_P5_SDI] &
                                p5_pin_in[PPC_P5_SDI]; // R2 R5
    pin_to_periph.tmr8_cnt_in = alt[PPC_P5_TI8] & ~fsel[PPC_P5_TI8] &
                                p5_pin_in[PPC_P5_TI8]; // R7
    pin_to_periph.tmr16_cap_in = alt[PPC_P5_TMR16] & ~fsel[PPC_P5_TMR16] &
                                 p5_pin_in[PPC_P5_TMR16]; // R8
  end

  // pull-ups follow their control bits regardless of mode
  assign p5_pullup_en = st_r.p5_pull[5:0]; // R9

  // port 7 has no direction control: straight to the converter
  assign analog_channel_input = p7_pin_in; // R10
  assign p7_level             = p7_pin_in;

  // port 9 drive, only implemented bits ever drive
  assign p9_pin_out = st_r.p9_lat & PPC_P9_MASK; // R12
  assign p9_pin_oe  = ~st_r.p9_dir & PPC_P9_MASK; // R13 R11

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_mode_hi_zero;
    st_r.p5_mode[7:6] == 2'b00 && st_r.p5_func[7:6] == 2'b00;
  endproperty
  a_mode_hi_zero: assert property (p_mode_hi_zero) // R1
    else $error("port 5 mode or function bits 7:6 not zero");

  property p_kr_gate;
    pin_to_periph.key_return == (p5_pin_in & ~st_r.p5_mode[5:0]);
  endproperty
  a_kr_gate: assert property (p_kr_gate) // R2
    else $error("key return not gated by mode");

  property p_sck_rtp;
    st_r.p5_mode[5] && st_r.p5_func[5]
      |-> p5_pin_oe[5] && p5_pin_out[5] == periph.rtp[5];
  endproperty
  a_sck_rtp: assert property (p_sck_rtp) // R3
    else $error("pin 5 does not drive rtp5");

  property p_sdo_sel;
    st_r.p5_mode[4] && !st_r.p5_func[4]
      |-> p5_pin_oe[4] && p5_pin_out[4] == periph.csi_data_out;
  endproperty
  a_sdo_sel: assert property (p_sdo_sel) // R4
    else $error("pin 4 does not drive serial data");

  property p_sdi_in;
    st_r.p5_mode[3] && !st_r.p5_func[3]
      |-> !p5_pin_oe[3] && pin_to_periph.csi_data_in == p5_pin_in[3];
  endproperty
  a_sdi_in: assert property (p_sdi_in) // R5
    else $error("pin 3 not serial input");

  property p_to8;
    st_r.p5_mode[2] && !st_r.p5_func[2]
      |-> p5_pin_out[2] == periph.tmr8_out;
  endproperty
  a_to8: assert property (p_to8) // R6
    else $error("pin 2 not timer output");

  property p_pull;
    wr_take && pstrb[0] && idx == PPC_IDX_P5_PULL[PPC_DEC_W-1:0]
      |=> p5_pullup_en == $past(pwdata[5:0]);
  endproperty
  a_pull: assert property (p_pull) // R9
    else $error("pull-up enable did not follow write");

  property p_p9_oe;
    p9_pin_oe == (~st_r.p9_dir & PPC_P9_MASK) &&
    (p9_pin_oe & ~PPC_P9_MASK) == 16'h0000;
  endproperty
  a_p9_oe: assert property (p_p9_oe) // R13
    else $error("port 9 enable does not match direction");

  property p_lat_hi;
    wr_take && pstrb[0] && idx == PPC_IDX_P9_LAT_H[PPC_DEC_W-1:0]
      |=> p9_pin_out[15:8] == ($past(pwdata[7:0]) & PPC_P9_MASK[15:8]);
  endproperty
  a_lat_hi: assert property (p_lat_hi) // R14
    else $error("high alias write missed latch bits 15:8");

  property p_read_mix;
    setup && idx == PPC_IDX_P9_LAT[PPC_DEC_W-1:0]
      |=> prdata[15:0] == $past(p9_read) && prdata[31:16] == 16'h0000;
  endproperty
  a_read_mix: assert property (p_read_mix) // R17
    else $error("port 9 read wrong");

  // port-mode pins must follow the outside latch and drive enable
  property p_port_mode;
    ((p5_pin_oe ^ p5_port_oe) & ~st_r.p5_mode[5:0]) == 6'h00 &&
    ((p5_pin_out ^ p5_port_out) & ~st_r.p5_mode[5:0]) == 6'h00;
  endproperty
  a_port_mode: assert property (p_port_mode) // R1
    else $error("port mode pin not following port latch");

  // serial clock leg: drive follows the serial unit, level goes back
  property p_sck_csi;
    st_r.p5_mode[5] && !st_r.p5_func[5]
      |-> p5_pin_oe[5] == periph.csi_clk_oe &&
          p5_pin_out[5] == periph.csi_clk_out &&
          pin_to_periph.csi_clk_in == p5_pin_in[5];
  endproperty
  a_sck_csi: assert property (p_sck_csi) // R3
    else $error("pin 5 not serial clock");

  property p_rtp4;
    st_r.p5_mode[4] && st_r.p5_func[4]
      |-> p5_pin_oe[4] && p5_pin_out[4] == periph.rtp[4];
  endproperty
  a_rtp4: assert property (p_rtp4) // R4
    else $error("pin 4 does not drive rtp4");

  property p_rtp3;
    st_r.p5_mode[3] && st_r.p5_func[3]
      |-> p5_pin_oe[3] && p5_pin_out[3] == periph.rtp[3];
  endproperty
  a_rtp3: assert property (p_rtp3) // R5
    else $error("pin 3 does not drive rtp3");

  property p_rtp2;
    st_r.p5_mode[2] && st_r.p5_func[2]
      |-> p5_pin_oe[2] && p5_pin_out[2] == periph.rtp[2];
  endproperty
  a_rtp2: assert property (p_rtp2) // R6
    else $error("pin 2 does not drive rtp2");

  // timer count input: pin released, level handed to the timer
  property p_ti8_in;
    st_r.p5_mode[1] && !st_r.p5_func[1]
      |-> !p5_pin_oe[1] && pin_to_periph.tmr8_cnt_in == p5_pin_in[1];
  endproperty
  a_ti8_in: assert property (p_ti8_in) // R7
    else $error("pin 1 not timer count input");

  property p_rtp1;
    st_r.p5_mode[1] && st_r.p5_func[1]
      |-> p5_pin_oe[1] && p5_pin_out[1] == periph.rtp[1];
  endproperty
  a_rtp1: assert property (p_rtp1) // R7
    else $error("pin 1 does not drive rtp1");

  // capture input: pin released, level handed to the capture unit
  property p_cap_in;
    st_r.p5_mode[0] && !st_r.p5_func[0]
      |-> !p5_pin_oe[0] && pin_to_periph.tmr16_cap_in == p5_pin_in[0];
  endproperty
  a_cap_in: assert property (p_cap_in) // R8
    else $error("pin 0 not capture input");

  property p_rtp0;
    st_r.p5_mode[0] && st_r.p5_func[0]
      |-> p5_pin_oe[0] && p5_pin_out[0] == periph.rtp[0];
  endproperty
  a_rtp0: assert property (p_rtp0) // R8
    else $error("pin 0 does not drive rtp0");

  // port 7 is a wire: no register may sit in the way
  property p_p7_pass;
    analog_channel_input == p7_pin_in && p7_level == p7_pin_in;
  endproperty
  a_p7_pass: assert property (p_p7_pass) // R10
    else $error("port 7 does not pass pin levels");

  // missing port 9 bits never show up in a read
  property p_p9_rd_zero;
    (p9_read & ~PPC_P9_MASK) == 16'h0000;
  endproperty
  a_p9_rd_zero: assert property (p_p9_rd_zero) // R11
    else $error("unimplemented port 9 bit reads nonzero");

  // word write to the latch lands on the high byte too
  property p_lat_word;
    wr_take && pstrb[1] && idx == PPC_IDX_P9_LAT[PPC_DEC_W-1:0]
      |=> p9_pin_out[15:8] == ($past(pwdata[15:8]) & PPC_P9_MASK[15:8]);
  endproperty
  a_lat_word: assert property (p_lat_word) // R14
    else $error("word write missed latch bits 15:8");

  // high direction alias sets the enables of bits 15:8
  property p_dir_hi;
    wr_take && pstrb[0] && idx == PPC_IDX_P9_DIR_H[PPC_DEC_W-1:0]
      |=> p9_pin_oe[15:8] == (~$past(pwdata[7:0]) & PPC_P9_MASK[15:8]);
  endproperty
  a_dir_hi: assert property (p_dir_hi) // R15
    else $error("high direction alias missed bits 15:8");

  // the latch takes a write whatever the direction says
  property p_lat_any_dir;
    wr_take && pstrb[0] && idx == PPC_IDX_P9_LAT[PPC_DEC_W-1:0]
      |=> p9_pin_out[7:0] == ($past(pwdata[7:0]) & PPC_P9_MASK[7:0]);
  endproperty
  a_lat_any_dir: assert property (p_lat_any_dir) // R18
    else $error("latch write lost low byte");

endmodule : ppc_port_ctrl

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps

// bench for the port 5/7/9 pin control block, driven over apb
module testbench
  import ppc_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [5:0]  p5_pin_in;
  logic [5:0]  p5_pin_out;
  logic [5:0]  p5_pin_oe;
  logic [5:0]  p5_pullup_en;
  logic [5:0]  p5_port_out;
  logic [5:0]  p5_port_oe;
  ppc_periph_t periph;
  ppc_pin_in_t pin_to_periph;
  logic [7:0]  p7_pin_in;
  logic [7:0]  analog_channel_input;
  logic [7:0]  p7_level;
  logic [15:0] p9_pin_in;
  logic [15:0] p9_pin_out;
  logic [15:0] p9_pin_oe;
  int          num_errors;       // mismatches seen
  int          samples_checked;  // comparisons made
  int          cyc = 0;          // cycles since start, for the hang guard
  logic [31:0] rd;               // last read data
  logic        er;               // last error response

  ppc_port_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .p5_pin_in(p5_pin_in), .p5_pin_out(p5_pin_out), .p5_pin_oe(p5_pin_oe),
    .p5_pullup_en(p5_pullup_en), .p5_port_out(p5_port_out),
    .p5_port_oe(p5_port_oe), .periph(periph), .pin_to_periph(pin_to_periph),
    .p7_pin_in(p7_pin_in), .analog_channel_input(analog_channel_input),
    .p7_level(p7_level), .p9_pin_in(p9_pin_in), .p9_pin_out(p9_pin_out),
    .p9_pin_oe(p9_pin_oe));

  // 100 mhz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // hang guard: the whole run needs a few hundred cycles at most
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc > 5000) begin
      num_errors++;
      end_sim();
    end
  end

  // one compare for every kind of result but pready (checked inside apb), widened to a word
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one apb transfer; index is turned into a byte address (index * 4)
  task automatic apb(input logic w, input logic [31:0] idx,
                     input logic [31:0] d, input logic [3:0] s);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {18'h0, idx[11:0], 2'b00};
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for the answer, never assuming a latency; hang guard ends it
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    if (pready !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED pready expected 1 seen %b", pready);
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // idle edge so the next setup is not assigned in this time step
    @(posedge pclk);
  endtask : apb

  // program port 5 mode and function, then look at the pins
  task automatic p5_case(input logic [7:0] m, input logic [7:0] f,
                         input logic [5:0] oe, input logic [5:0] ov,
                         input logic [9:0] tp);
    apb(1'b1, PPC_IDX_P5_MODE, {24'h0, m}, 4'h1);
    apb(1'b1, PPC_IDX_P5_FUNC, {24'h0, f}, 4'h1);
    chk("p5_pin_oe", 32'(oe), 32'(p5_pin_oe));
    chk("p5_pin_out", 32'(ov), 32'(p5_pin_out & p5_pin_oe));
    chk("pin_to_periph", 32'(tp), 32'(pin_to_periph));
  endtask : p5_case

  // verdict in one place
  task automatic end_sim();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  initial begin
    num_errors = 0;
    samples_checked = 0;
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'b000;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    // distinct patterns so a wrong mux leg shows up
    p5_pin_in = 6'h2d;
    p5_port_out = 6'h1e;
    p5_port_oe = 6'h2a;
    periph = '{rtp: 6'h33, csi_clk_out: 1'b0, csi_clk_oe: 1'b1,
               csi_data_out: 1'b1, tmr8_out: 1'b1};
    p7_pin_in = 8'ha5;
    p9_pin_in = 16'h1234;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset state
    chk("p9_pin_oe", 32'h0, 32'(p9_pin_oe));
    chk("p9_pin_out", 32'h0, 32'(p9_pin_out));
    chk("p5_pullup_en", 32'h0, 32'(p5_pullup_en));
    apb(1'b0, PPC_IDX_P9_DIR, 32'h0, 4'h0);
    chk("p9_dir", 32'h0000e3c3, rd);
    apb(1'b0, PPC_IDX_P9_LAT, 32'h0, 4'h0);
    chk("p9_lat", 32'h00000200, rd);
    // port 7 is a plain input path
    chk("analog_in", 32'h0a5, 32'(analog_channel_input));
    chk("p7_level", 32'h0a5, 32'(p7_level));
    // latch written while every pin is still an input
    apb(1'b1, PPC_IDX_P9_LAT, 32'h0000ffff, 4'h3);
    chk("p9_pin_out", 32'he3c3, 32'(p9_pin_out));
    chk("p9_pin_oe", 32'h0, 32'(p9_pin_oe));
    apb(1'b1, PPC_IDX_P9_DIR, 32'h0, 4'h3);
    chk("p9_pin_oe", 32'he3c3, 32'(p9_pin_oe));
    apb(1'b0, PPC_IDX_P9_LAT, 32'h0, 4'h0);
    chk("p9_lat", 32'h0000e3c3, rd);
    // high byte aliases land on bits 15:8
    apb(1'b1, PPC_IDX_P9_DIR_H, 32'h000000ff, 4'h1);
    apb(1'b0, PPC_IDX_P9_DIR, 32'h0, 4'h0);
    chk("p9_dir", 32'h0000e300, rd);
    chk("p9_pin_oe", 32'h00c3, 32'(p9_pin_oe));
    apb(1'b0, PPC_IDX_P9_LAT_H, 32'h0, 4'h0);
    chk("p9_lat_h", 32'h00000002, rd);
    apb(1'b1, PPC_IDX_P9_LAT_H, 32'h0, 4'h1);
    chk("p9_pin_out", 32'h00c3, 32'(p9_pin_out));
    // only the byte with its strobe set is written
    apb(1'b1, PPC_IDX_P9_LAT, 32'h0000aaaa, 4'h2);
    chk("p9_pin_out", 32'ha2c3, 32'(p9_pin_out));
    // unmapped index answers with an error and zero data
    apb(1'b0, 32'h0, 32'h0, 4'h0);
    chk("unmapped_data", 32'h0, rd);
    chk("unmapped_err", 32'h1, 32'(er));
    // pull-ups follow their bits
    apb(1'b1, PPC_IDX_P5_PULL, 32'h0000002a, 4'h1);
    chk("p5_pullup_en", 32'h2a, 32'(p5_pullup_en));
    apb(1'b0, PPC_IDX_P5_PULL, 32'h0, 4'h0);
    chk("p5_pull", 32'h0000002a, rd);
    // port 5 mux: port mode, pin 3 alone, all timers/serial, all rtp
    p5_case(8'h00, 8'h00, 6'h2a, 6'h0a, 10'b101101_0000);
    p5_case(8'h08, 8'h00, 6'h22, 6'h02, 10'b100101_0100);
    p5_case(8'h3f, 8'h00, 6'h34, 6'h14, 10'b000000_1101);
    p5_case(8'hff, 8'hff, 6'h3f, 6'h33, 10'b000000_0000);
    apb(1'b0, PPC_IDX_P5_MODE, 32'h0, 4'h0);
    chk("p5_mode", 32'h0000003f, rd);
    apb(1'b0, PPC_IDX_P5_FUNC, 32'h0, 4'h0);
    chk("p5_func", 32'h0000003f, rd);
    end_sim();
  end
endmodule : testbench
